// [mic_irq_ctrl.v]
// Interrupt control for a small microcontroller core: flags, enables, vectoring, wake.
//
// Notes on behaviour
// RULE_01: Exactly four sources: timer overflow, external pin, port change, converter done.
// RULE_02: Each flag sets on its event whatever its enable or the global enable.
// RULE_03: Global enable at control bit 7 allows unmasked interrupts, else blocks all.
// RULE_04: Global enable with any flagged and enabled source takes the interrupt at once; the code accepts only in the fourth phase and not during sleep.
// RULE_05: Every reset clears the global enable.
// RULE_06: Return-from-interrupt instruction sets the global enable again.
// RULE_07: Converter flag and enable in peripheral registers, also gated by peripheral enable.
// RULE_08: Accepting clears global enable, pushes return address, loads the fixed vector.
// RULE_09: Software clears flags before re-enabling; hardware never clears them.
// RULE_10: External event to vector takes three or four cycles, same for any instruction.
// RULE_11: External-pin flag may only be set during the fourth and first phases.
// RULE_12: Timer rollover from maximum to zero sets the timer flag at bit 2.
// RULE_13: Timer overflow request is enabled by control bit 5.
// RULE_14: External pin is edge-triggered, edge chosen by option bit 6, flag bit 1.
// RULE_15: Clearing control bit 4 disables the external-pin interrupt.
// RULE_16: Enabled external-pin event wakes from sleep; global enable then decides branching.
// RULE_17: Change on port pins 3, 1, 0 sets flag bit 0, enable bit 3.
// RULE_18: Entry saves only the return address; working and status registers are untouched.
// RULE_19: Flagged and enabled source wakes from sleep whatever the global enable.
// RULE_20: Request is global enable AND the OR of all flag-enable pairs.
// RULE_21: One shared vector, no priority; software polls the flags.
`timescale 1ns/1ps
`include "mic_regs.vh"
module mic_irq_ctrl (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        ext_irq_pin,
	input  wire        port_pin_zero,
	input  wire        port_pin_one,
	input  wire        port_pin_three,
	input  wire [7:0]  timer_count,
	input  wire        conv_done_event,
	input  wire [7:0]  option_value,
	input  wire        ctrl_wr,
	input  wire [7:0]  ctrl_wdata,
	input  wire        periph_flag_wr,
	input  wire [7:0]  periph_flag_wdata,
	input  wire        periph_enable_wr,
	input  wire [7:0]  periph_enable_wdata,
	input  wire        return_from_irq_instr,
	input  wire        sleep_active,
	output wire [7:0]  irq_control_reg,
	output wire [7:0]  periph_flag_reg,
	output wire [7:0]  periph_enable_reg,
	output wire        global_irq_enable,
	output wire        irq_request,
	output wire        wake_request,
	output wire        irq_flush,
	output reg         stack_push_q,
	output reg         pc_load_q,
	output reg  [12:0] pc_vector_q,
	output reg  [1:0]  q_phase_q
);
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_FLUSH = 2'h1;
	localparam [1:0] ST_VECT  = 2'h2;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         glb_en_q;
	reg         ext_prev_q;
	reg         ext_pend_q;
	reg  [2:0]  port_prev_q;
	reg  [2:0]  prime_q;
	reg  [7:0]  tmr_prev_q;
	wire        ext_sync;
	wire [2:0]  port_sync;
	wire        ext_rise;
	wire        ext_fall;
	wire        ext_edge;
	wire        ext_window;
	wire        port_change;
	wire        tmr_ovf;
	wire        accept;
	wire        any_pending;
	wire        tmr_flag;
	wire        ext_flag;
	wire        port_flag;
	wire        tmr_en;
	wire        ext_en;
	wire        port_en;
	wire        peie;
	wire        conv_flag;
	wire        conv_en;

	// Pins come from outside the clock domain and are synchronised first.
	mic_sync #(
		.W (1)
	) u_ext_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (ext_irq_pin),
		.sync_q   (ext_sync)
	);

	mic_sync #(
		.W (`MIC_PORT_PINS)
	) u_port_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({port_pin_three, port_pin_one, port_pin_zero}),
		.sync_q   (port_sync)
	);

	// Instruction cycle is four clock phases; the core follows this phase count.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			q_phase_q <= `MIC_Q1;
		else
			q_phase_q <= q_phase_q + 2'h1;
	end

	// External pin edge detection with a pending latch held until the legal phases.
	assign ext_rise   = ext_sync & ~ext_prev_q;
	assign ext_fall   = ~ext_sync & ext_prev_q;
	assign ext_edge   = prime_q[2] & (option_value[`MIC_OPT_EDGE] ? ext_rise : ext_fall); // RULE_14
	assign ext_window = (q_phase_q == `MIC_Q4) | (q_phase_q == `MIC_Q1); // RULE_11

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_prev_q <= 1'b0;
			ext_pend_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_sync;
			ext_pend_q <= (ext_pend_q | ext_edge) & ~ext_window;
		end
	end

	// Port change compares against the previous sample. The synchronisers and the
	// history need three edges after reset to hold real pin levels, so no change or
	// edge is trusted before then; a pin idling high would otherwise fake an event.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port_prev_q <= 3'h0;
			prime_q     <= 3'h0;
		end else begin
			port_prev_q <= port_sync;
			prime_q     <= {prime_q[1:0], 1'b1};
		end
	end

	assign port_change = prime_q[2] & (|(port_sync ^ port_prev_q)); // RULE_17

	// Timer runs on this clock, so its count is compared without synchronising.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			tmr_prev_q <= `MIC_TMR_ZERO;
		else
			tmr_prev_q <= timer_count;
	end

	assign tmr_ovf = (tmr_prev_q == `MIC_TMR_MAX) & (timer_count == `MIC_TMR_ZERO); // RULE_12

	// Flags: events set them regardless of any enable; only writes clear them.
	mic_flag u_tmr_flag (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (tmr_ovf), // RULE_02
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_TMR_FLAG]),
		.flag_q  (tmr_flag)
	);

	mic_flag u_ext_flag (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  ((ext_edge | ext_pend_q) & ext_window), // RULE_11
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_EXT_FLAG]),
		.flag_q  (ext_flag)
	);

	mic_flag u_port_flag (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (port_change), // RULE_02
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_PORT_FLAG]),
		.flag_q  (port_flag)
	);

	mic_flag u_conv_flag (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (conv_done_event), // RULE_07
		.sw_wr   (periph_flag_wr),
		.sw_data (periph_flag_wdata[`MIC_PERIPH_CONV]),
		.flag_q  (conv_flag)
	);

	// Enables are plain software bits with no hardware set.
	mic_flag u_tmr_en (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (1'b0),
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_TMR_EN]), // RULE_13
		.flag_q  (tmr_en)
	);

	mic_flag u_ext_en (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (1'b0),
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_EXT_EN]), // RULE_15
		.flag_q  (ext_en)
	);

	mic_flag u_port_en (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (1'b0),
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_PORT_EN]), // RULE_17
		.flag_q  (port_en)
	);

	mic_flag u_peie (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (1'b0),
		.sw_wr   (ctrl_wr),
		.sw_data (ctrl_wdata[`MIC_CTRL_PEIE]), // RULE_07
		.flag_q  (peie)
	);

	mic_flag u_conv_en (
		.clk     (clk),
		.reset_n (reset_n),
		.hw_set  (1'b0),
		.sw_wr   (periph_enable_wr),
		.sw_data (periph_enable_wdata[`MIC_PERIPH_CONV]), // RULE_07
		.flag_q  (conv_en)
	);

	// All four sources merge into one request with no priority between them.
	assign any_pending = (tmr_flag & tmr_en) | (ext_flag & ext_en) | (port_flag & port_en)
		| (conv_flag & conv_en & peie); // RULE_01 RULE_07 RULE_21
	assign irq_request = glb_en_q & any_pending; // RULE_03 RULE_20

	// Wake ignores the global enable; after wake the core runs the next instruction
	// and then the ordinary request path branches only if the global enable is set.
	assign wake_request = sleep_active & any_pending; // RULE_16 RULE_19

	// Acceptance happens at a cycle boundary so that one- and two-cycle instructions
	// see the same latency. The core is flushed for two cycles and gets the vector in
	// the last phase of the second, so the handler starts on a cycle boundary.
	assign accept = (state_q == ST_IDLE) & irq_request & ~sleep_active
		& (q_phase_q == `MIC_Q4); // RULE_04 RULE_10

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept)
					state_d = ST_FLUSH;
			end
			ST_FLUSH: begin
				if (q_phase_q == `MIC_Q4)
					state_d = ST_VECT;
			end
			ST_VECT: begin
				if (q_phase_q == `MIC_Q4)
					state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Only the return address is pushed; working and status registers stay with software.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stack_push_q <= 1'b0;
			pc_load_q    <= 1'b0;
			pc_vector_q  <= `MIC_VECTOR;
		end else begin
			stack_push_q <= (state_q == ST_VECT) & (q_phase_q == `MIC_Q3); // RULE_08 RULE_18
			pc_load_q    <= (state_q == ST_VECT) & (q_phase_q == `MIC_Q3); // RULE_08 RULE_10
			pc_vector_q  <= `MIC_VECTOR; // RULE_21
		end
	end

	assign irq_flush = (state_q != ST_IDLE); // RULE_10

	// Acceptance outranks a write or a return in the same cycle, so a taken interrupt
	// always starts its handler with interrupts blocked.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			glb_en_q <= 1'b0; // RULE_05
		else if (accept)
			glb_en_q <= 1'b0; // RULE_08
		else if (return_from_irq_instr)
			glb_en_q <= 1'b1; // RULE_06
		else if (ctrl_wr)
			glb_en_q <= ctrl_wdata[`MIC_CTRL_GLB_EN]; // RULE_03
	end

	// Flags are never cleared here; a flag left set re-enters the handler after return.
	assign irq_control_reg = {glb_en_q, peie, tmr_en, ext_en,
		port_en, tmr_flag, ext_flag, port_flag}; // RULE_09
	assign global_irq_enable = glb_en_q;
	assign periph_flag_reg   = {1'b0, conv_flag, 6'h00};
	assign periph_enable_reg = {1'b0, conv_en, 6'h00};
endmodule // mic_irq_ctrl

// [mic_regs.vh]
// Constants for the interrupt control block: bit positions, codes and timing.
`ifndef MIC_REGS_VH
`define MIC_REGS_VH
`define MIC_CTRL_GLB_EN     7
`define MIC_CTRL_PEIE       6
`define MIC_CTRL_TMR_EN     5
`define MIC_CTRL_EXT_EN     4
`define MIC_CTRL_PORT_EN    3
`define MIC_CTRL_TMR_FLAG   2
`define MIC_CTRL_EXT_FLAG   1
`define MIC_CTRL_PORT_FLAG  0
`define MIC_PERIPH_CONV     6
`define MIC_OPT_EDGE        6
`define MIC_CTRL_RESET      8'h00
`define MIC_PERIPH_RESET    8'h00
`define MIC_VECTOR          13'h0004
`define MIC_TMR_MAX         8'hff
`define MIC_TMR_ZERO        8'h00
`define MIC_Q1              2'h0
`define MIC_Q2              2'h1
`define MIC_Q3              2'h2
`define MIC_Q4              2'h3
`define MIC_PORT_PINS       3
`endif

// [mic_sync.v]
// Two flip-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module mic_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         reset_n,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_q
);
	reg [W-1:0] meta_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule // mic_sync

// [mic_flag.v]
// One software-visible bit that hardware may set and software may write.
`timescale 1ns/1ps
module mic_flag (
	input  wire clk,
	input  wire reset_n,
	input  wire hw_set,
	input  wire sw_wr,
	input  wire sw_data,
	output reg  flag_q
);
	// A hardware set in the same cycle as a software clear wins, so no event is lost.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			flag_q <= 1'b0;
		else
			flag_q <= hw_set | (sw_wr ? sw_data : flag_q);
	end
endmodule // mic_flag

// [mic_core_model.sv]
// Core sequencer model: program counter, return stack and return pulse.
`timescale 1ns/1ps
module mic_core_model (
	input  logic        clk,
	input  logic        reset_n,
	input  logic        stack_push_q,
	input  logic        pc_load_q,
	input  logic [12:0] pc_vector_q,
	input  logic        ret_go,
	output logic        return_from_irq_instr,
	output logic [12:0] pc_q,
	output logic [3:0]  depth_q
);
	logic [12:0] stk_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q <= 13'h0010;
			stk_q <= 13'h0000;
			depth_q <= 4'h0;
			return_from_irq_instr <= 1'b0;
		end else begin
			return_from_irq_instr <= ret_go;
			if (stack_push_q && pc_load_q) begin
				stk_q <= pc_q;
				depth_q <= depth_q + 4'h1;
				pc_q <= pc_vector_q;
			end else if (return_from_irq_instr) begin
				pc_q <= stk_q;
				depth_q <= depth_q - 4'h1;
			end
		end
	end
endmodule // mic_core_model

// [mic_irq_ctrl_assertions.sv]
// Port-level assertions for the interrupt control block.
`timescale 1ns/1ps
module mic_irq_ctrl_checker (
	input logic        clk,
	input logic        reset_n,
	input logic [7:0]  timer_count,
	input logic        conv_done_event,
	input logic        ctrl_wr,
	input logic        return_from_irq_instr,
	input logic        sleep_active,
	input logic [7:0]  irq_control_reg,
	input logic [7:0]  periph_flag_reg,
	input logic [7:0]  periph_enable_reg,
	input logic        global_irq_enable,
	input logic        irq_request,
	input logic        wake_request,
	input logic        irq_flush,
	input logic        stack_push_q,
	input logic        pc_load_q,
	input logic [12:0] pc_vector_q,
	input logic [1:0]  q_phase_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic pairs;
	logic accept;
	assign pairs = (|(irq_control_reg[5:3] & irq_control_reg[2:0]))
		| (irq_control_reg[6] & periph_enable_reg[6] & periph_flag_reg[6]);
	assign accept = q_phase_q == 2'h3 && irq_request && !sleep_active && !irq_flush;
	sequence s_enter;
		irq_flush && !global_irq_enable;
	endsequence
	sequence s_vect;
		stack_push_q && pc_load_q && pc_vector_q == 13'h0004;
	endsequence
	AST_ACCEPT: assert property (accept |=> s_enter ##7 s_vect)
		else $error("vector entry out of order");
	AST_REQ: assert property (irq_request == (global_irq_enable & pairs))
		else $error("request not gated by global enable");
	AST_WAKE: assert property (wake_request == (sleep_active & pairs))
		else $error("wake request wrong");
	AST_FLUSH: assert property ($rose(irq_flush) |-> irq_flush [*8] ##1 !irq_flush)
		else $error("flush length wrong");
	AST_TMR: assert property ($past(timer_count) == 8'hff && timer_count == 8'h00
		|=> irq_control_reg[2])
		else $error("timer rollover flag missing");
	AST_CONV: assert property (conv_done_event |=> periph_flag_reg[6])
		else $error("converter flag missing");
	AST_RET: assert property (return_from_irq_instr && !accept |=> global_irq_enable)
		else $error("return did not set global enable");
	AST_SLEEP: assert property (sleep_active && !irq_flush |=> !irq_flush)
		else $error("interrupt taken while asleep");
	AST_EXTPH: assert property ($rose(irq_control_reg[1]) && !$past(ctrl_wr)
		|-> $past(q_phase_q) inside {2'h3, 2'h0})
		else $error("pin flag set in wrong phase");
	AST_PULSE: assert property (stack_push_q |=> !stack_push_q && !pc_load_q)
		else $error("push pulse too long");
endmodule // mic_irq_ctrl_checker
bind mic_irq_ctrl mic_irq_ctrl_checker i_chk (.clk(clk), .reset_n(reset_n),
	.timer_count(timer_count), .conv_done_event(conv_done_event), .ctrl_wr(ctrl_wr),
	.return_from_irq_instr(return_from_irq_instr), .sleep_active(sleep_active),
	.irq_control_reg(irq_control_reg), .periph_flag_reg(periph_flag_reg),
	.periph_enable_reg(periph_enable_reg), .global_irq_enable(global_irq_enable),
	.irq_request(irq_request), .wake_request(wake_request), .irq_flush(irq_flush),
	.stack_push_q(stack_push_q), .pc_load_q(pc_load_q), .pc_vector_q(pc_vector_q),
	.q_phase_q(q_phase_q));

// [tb_mic_irq_ctrl.sv]
// Self-checking testbench for the interrupt control block.
`timescale 1ns/1ps
module tb_mic_irq_ctrl;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ext_pin = 1'b0;
	logic [2:0]  pins = 3'h0;
	logic [7:0]  tcnt = 8'h00;
	logic        conv_ev = 1'b0;
	logic [7:0]  opt = 8'h00;
	logic        cwr = 1'b0;
	logic [7:0]  cwd = 8'h00;
	logic        pfwr = 1'b0;
	logic [7:0]  pfwd = 8'h00;
	logic        pewr = 1'b0;
	logic [7:0]  pewd = 8'h00;
	logic        sleep = 1'b0;
	logic        ret_go = 1'b0;
	logic        ret, glb_en, req, wake, flush, push, pload;
	logic [7:0]  creg, pfreg, pereg;
	logic [12:0] pvec, cpc;
	logic [1:0]  qph;
	logic [3:0]  depth;
	int          n_fail = 0;
	int          cmp_count = 0;
	always #2.5 clk = ~clk;
	mic_irq_ctrl i_dut (.clk(clk), .reset_n(reset_n), .ext_irq_pin(ext_pin),
		.port_pin_zero(pins[0]), .port_pin_one(pins[1]), .port_pin_three(pins[2]),
		.timer_count(tcnt), .conv_done_event(conv_ev), .option_value(opt),
		.ctrl_wr(cwr), .ctrl_wdata(cwd), .periph_flag_wr(pfwr), .periph_flag_wdata(pfwd),
		.periph_enable_wr(pewr), .periph_enable_wdata(pewd), .return_from_irq_instr(ret),
		.sleep_active(sleep), .irq_control_reg(creg), .periph_flag_reg(pfreg),
		.periph_enable_reg(pereg), .global_irq_enable(glb_en), .irq_request(req),
		.wake_request(wake), .irq_flush(flush), .stack_push_q(push), .pc_load_q(pload),
		.pc_vector_q(pvec), .q_phase_q(qph));
	mic_core_model i_core (.clk(clk), .reset_n(reset_n), .stack_push_q(push),
		.pc_load_q(pload), .pc_vector_q(pvec), .ret_go(ret_go),
		.return_from_irq_instr(ret), .pc_q(cpc), .depth_q(depth));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_ctrl(input logic [7:0] d);
		cwd = d;
		cwr = 1'b1;
		cyc(1);
		cwr = 1'b0;
	endtask
	task automatic wait_vec(output int n);
		n = 0;
		while (pload !== 1'b1) begin
			cyc(1);
			n++;
			if (n > 40) begin
				n_fail++;
				summarize();
			end
		end
	endtask
	// Returns only after the flush has drained, so no entry overlaps the exit.
	task automatic do_ret();
		cyc(4);
		ret_go = 1'b1;
		cyc(1);
		ret_go = 1'b0;
		cyc(2);
	endtask
	task automatic t_timer();
		int n;
		wr_ctrl(8'ha0);
		tcnt = 8'hff;
		cyc(1);
		tcnt = 8'h00;
		wait_vec(n);
		chk("t0flag", 13'h1, 13'(creg[2]));
		chk("push", 13'h1, 13'(push));
		chk("glb_en_entry", 13'h0, 13'(glb_en));
		cyc(1);
		chk("core_pc", 13'h0004, cpc);
		chk("depth", 13'h1, 13'(depth));
		wr_ctrl(8'h20);
		do_ret();
		chk("glb_en_ret", 13'h1, 13'(glb_en));
		chk("req_clear", 13'h0, 13'(req));
		$display("test timer done");
	endtask
	task automatic t_ext();
		int n;
		for (int e = 0; e < 2; e++) begin
			// The pin first settles at the level the wrong edge starts from.
			ext_pin = e[0];
			cyc(6);
			opt = e[0] ? 8'h40 : 8'h00;
			ext_pin = ~e[0];
			cyc(6);
			chk("wrong_edge", 13'h0, 13'(creg[1]));
			wr_ctrl(8'h90);
			ext_pin = e[0];
			wait_vec(n);
			chk("lat_min", 13'h1, 13'(n >= 12));
			chk("lat_max", 13'h1, 13'(n <= 16));
			chk("ext_flag", 13'h1, 13'(creg[1]));
			wr_ctrl(8'h10);
			do_ret();
		end
		$display("test ext pin done");
	endtask
	task automatic t_mask();
		int n;
		wr_ctrl(8'h80);
		pins = 3'h5;
		conv_ev = 1'b1;
		cyc(1);
		conv_ev = 1'b0;
		cyc(4);
		chk("portflag", 13'h1, 13'(creg[0]));
		chk("convflag", 13'h1, 13'(pfreg[6]));
		chk("req_masked", 13'h0, 13'(req));
		pewd = 8'h40;
		pewr = 1'b1;
		cyc(1);
		pewr = 1'b0;
		chk("pe_en", 13'h0040, 13'(pereg));
		chk("req_noperiph", 13'h0, 13'(req));
		wr_ctrl(8'h49);
		chk("req_nogie", 13'h0, 13'(req));
		wr_ctrl(8'hc0);
		chk("req_conv", 13'h1, 13'(req));
		n = 0;
		while (flush !== 1'b1 && n < 8) begin
			cyc(1);
			n++;
		end
		chk("conv_wait", 13'h1, 13'(n <= 4));
		wait_vec(n);
		chk("conv_vec", 13'h0004, pvec);
		pfwd = 8'h00;
		pfwr = 1'b1;
		cyc(1);
		pfwr = 1'b0;
		do_ret();
		chk("conv_clear", 13'h0, 13'(pfreg[6]));
		$display("test mask done");
	endtask
	task automatic t_sleep();
		int n;
		wr_ctrl(8'h10);
		sleep = 1'b1;
		opt = 8'h00;
		ext_pin = 1'b0;
		n = 0;
		while (wake !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk("wake", 13'h1, 13'(wake));
		chk("no_req", 13'h0, 13'(req));
		chk("no_flush", 13'h0, 13'(flush));
		if (wake !== 1'b1)
			summarize();
		sleep = 1'b0;
		wr_ctrl(8'h00);
		$display("test sleep done");
	endtask
	initial begin
		cyc(5);
		reset_n = 1'b1;
		chk("ctrl_rst", 13'h0, 13'(creg));
		chk("pf_rst", 13'h0, 13'(pfreg));
		chk("vec_rst", 13'h0004, pvec);
		t_timer();
		t_ext();
		t_mask();
		t_sleep();
		summarize();
	end
endmodule // tb_mic_irq_ctrl
